//--- design/fspc_defines.vh
// Register offsets, reset values, fields and trim constants of the packet config bank
`ifndef FSPC_DEFINES_VH
`define FSPC_DEFINES_VH

// Register offsets
`define FSPC_ADDR_FILL_LEVEL_THRESHOLD 6'h03
`define FSPC_ADDR_SYNC_HIGH 6'h04
`define FSPC_ADDR_SYNC_LOW 6'h05
`define FSPC_ADDR_PKT_LEN 6'h06
`define FSPC_ADDR_TRIM_TWO 6'h2C
`define FSPC_ADDR_TRIM_ONE 6'h2D

// Reset values
`define FSPC_RST_FILL_LEVEL_THRESHOLD 8'h07
`define FSPC_RST_SYNC_HIGH 8'hD3
`define FSPC_RST_SYNC_LOW 8'h91
`define FSPC_RST_PKT_LEN 8'hFF
// Readback reset values of the trim registers; arbitrary neutral values
`define FSPC_RST_TRIM_ONE 8'h00
`define FSPC_RST_TRIM_TWO 8'h00

// Threshold register fields
`define FSPC_BIT_RESERVED 7
`define FSPC_BIT_RETENTION 6
`define FSPC_CLOSE_IN_HI 5
`define FSPC_CLOSE_IN_LO 4
`define FSPC_THR_HI 3
`define FSPC_THR_LO 0

// Threshold arithmetic
`define FSPC_TX_THR_BASE 7'h3D
`define FSPC_THR_STEP 7'h04

// Analog trims applied on wake
`define FSPC_TRIM_ONE_RET0 8'h31
`define FSPC_TRIM_TWO_RET0 8'h88
`define FSPC_TRIM_ONE_RET1 8'h35
`define FSPC_TRIM_TWO_RET1 8'h81

// Preamble quality counter
`define FSPC_PQ_DEC 8'h08
`define FSPC_PQ_MAX 8'hFF

`endif

//--- design/fspc_fifo_sync_packet_config.v
// Packet engine configuration bank: FIFO thresholds, sync word, length, trims
//
// Function
// - Retention 0: wake trims 0x31, 0x88
// - Retention 1: wake trims 0x35, 0x81
// - Trim reads always return reset values
// - Setting N: TX 61-4N, RX 4(N+1)
// - Threshold reached when count at least threshold
// - High register gives sync bits 15:8
// - Low register gives sync bits 7:0
// - Fixed mode: length register is exact length
// - Variable mode: length register is maximum
// - Preamble quality counter gates sync detection
`timescale 1ns/1ps
`default_nettype none
`include "fspc_defines.vh"

module fspc_fifo_sync_packet_config (
  // Clock and reset
  input wire i_clk_sys,
  input wire i_sys_rst,
  // Register port
  input wire [5:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  input wire i_reg_wr,
  input wire i_reg_rd,
  output reg [7:0] o_reg_rdata,
  output reg o_reg_rvalid,
  // Power state
  input wire i_wake,
  output reg [7:0] o_analog_trim_one,
  output reg [7:0] o_analog_trim_two,
  // FIFO fill levels
  input wire [6:0] i_tx_fifo_bytes,
  input wire [6:0] i_rx_fifo_bytes,
  output reg o_tx_thr_reached,
  output reg o_rx_thr_reached,
  // Sync word and close-in field
  output reg [15:0] o_sync_word,
  output reg [1:0] o_close_in_rx,
  // Packet length
  input wire i_len_fixed_mode,
  input wire [7:0] i_len_field,
  input wire i_len_field_valid,
  output reg [7:0] o_pkt_length,
  output reg o_pkt_len_reject,
  // Preamble quality
  input wire [2:0] i_preamble_quality_threshold,
  input wire i_rx_bit,
  input wire i_rx_bit_valid,
  input wire i_pq_restart,
  output reg o_sync_gate
);

  ////////////////////////////////////////////////////////////////////////////
  // Threshold arithmetic

  // Transmit threshold in bytes for setting n
  function [6:0] fspc_tx_thr;
    input [3:0] n;
    begin
      fspc_tx_thr = `FSPC_TX_THR_BASE - {n, 2'b00};
    end
  endfunction

  // Receive threshold in bytes for setting n
  function [6:0] fspc_rx_thr;
    input [3:0] n;
    begin
      fspc_rx_thr = {n, 2'b00} + `FSPC_THR_STEP;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register select

  // One-hot select of the addressed register, shared by writes and reads
  function [5:0] fspc_sel;
    input [5:0] addr;
    begin
      case (addr)
        `FSPC_ADDR_FILL_LEVEL_THRESHOLD: fspc_sel = 6'h01;
        `FSPC_ADDR_SYNC_HIGH: fspc_sel = 6'h02;
        `FSPC_ADDR_SYNC_LOW: fspc_sel = 6'h04;
        `FSPC_ADDR_PKT_LEN: fspc_sel = 6'h08;
        `FSPC_ADDR_TRIM_ONE: fspc_sel = 6'h10;
        `FSPC_ADDR_TRIM_TWO: fspc_sel = 6'h20;
        default: fspc_sel = 6'h00;
      endcase
    end
  endfunction

  wire [5:0] reg_sel;
  assign reg_sel = fspc_sel(i_reg_addr);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  reg [7:0] fifo_threshold_ctrl;
  reg [7:0] sync_word_high;
  reg [7:0] sync_word_low;
  reg [7:0] packet_length_limit;

  wire analog_retention_select;
  wire [3:0] fill_level_threshold;
  assign analog_retention_select = fifo_threshold_ctrl[`FSPC_BIT_RETENTION];
  assign fill_level_threshold =
    fifo_threshold_ctrl[`FSPC_THR_HI:`FSPC_THR_LO];

  // Bit 7 is stored as written; keeping it zero is up to the host
  // Trim selects have no storage, so host writes there are dropped
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      fifo_threshold_ctrl <= `FSPC_RST_FILL_LEVEL_THRESHOLD;
      sync_word_high <= `FSPC_RST_SYNC_HIGH;
      sync_word_low <= `FSPC_RST_SYNC_LOW;
      packet_length_limit <= `FSPC_RST_PKT_LEN;
    end else if (i_reg_wr) begin
      if (reg_sel[0]) begin
        fifo_threshold_ctrl <= i_reg_wdata;
      end
      if (reg_sel[1]) begin
        sync_word_high <= i_reg_wdata;
      end
      if (reg_sel[2]) begin
        sync_word_low <= i_reg_wdata;
      end
      if (reg_sel[3]) begin
        packet_length_limit <= i_reg_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  reg [7:0] next_rdata;

  always @* begin
    case (reg_sel)
      6'h01: next_rdata = fifo_threshold_ctrl;
      6'h02: next_rdata = sync_word_high;
      6'h04: next_rdata = sync_word_low;
      6'h08: next_rdata = packet_length_limit;
      6'h10: next_rdata = `FSPC_RST_TRIM_ONE;
      6'h20: next_rdata = `FSPC_RST_TRIM_TWO;
      // Unmapped reads return zero, never a stale byte
      default: next_rdata = 8'h00;
    endcase
  end

  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= next_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog trims on wake

  // Trims only reach the analog section; the readback above never shows them
  // Until the first wake the trims sit at the retention-clear values
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_analog_trim_one <= `FSPC_TRIM_ONE_RET0;
      o_analog_trim_two <= `FSPC_TRIM_TWO_RET0;
    end else if (i_wake) begin
      if (analog_retention_select) begin
        o_analog_trim_one <= `FSPC_TRIM_ONE_RET1;
        o_analog_trim_two <= `FSPC_TRIM_TWO_RET1;
      end else begin
        o_analog_trim_one <= `FSPC_TRIM_ONE_RET0;
        o_analog_trim_two <= `FSPC_TRIM_TWO_RET0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // FIFO threshold indications

  wire [6:0] tx_thr;
  wire [6:0] rx_thr;
  assign tx_thr = fspc_tx_thr(fill_level_threshold);
  assign rx_thr = fspc_rx_thr(fill_level_threshold);

  // Indications lag the fill counts by one cycle
  // A new setting reaches the flags two cycles after its write strobe
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_tx_thr_reached <= 1'b0;
      o_rx_thr_reached <= 1'b0;
    end else begin
      o_tx_thr_reached <= (i_tx_fifo_bytes >= tx_thr);
      o_rx_thr_reached <= (i_rx_fifo_bytes >= rx_thr);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sync word and close-in field

  // Sync word follows its registers one cycle late
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_sync_word <= {`FSPC_RST_SYNC_HIGH, `FSPC_RST_SYNC_LOW};
      o_close_in_rx <= 2'b00;
    end else begin
      o_sync_word[15:8] <= sync_word_high;
      o_sync_word[7:0] <= sync_word_low;
      // Close-in field passed through raw; its encoding is left open
      o_close_in_rx <=
        fifo_threshold_ctrl[`FSPC_CLOSE_IN_HI:`FSPC_CLOSE_IN_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Packet length

  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_pkt_length <= `FSPC_RST_PKT_LEN;
      o_pkt_len_reject <= 1'b0;
    end else if (i_len_fixed_mode) begin
      o_pkt_length <= packet_length_limit;
      o_pkt_len_reject <= 1'b0;
    end else if (i_len_field_valid) begin
      // variable length ceiling
      // A field equal to the limit passes; only a longer one is clipped
      if (i_len_field > packet_length_limit) begin
        o_pkt_length <= packet_length_limit;
        o_pkt_len_reject <= 1'b1;
      end else begin
        o_pkt_length <= i_len_field;
        o_pkt_len_reject <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Preamble quality estimator

  reg [7:0] pq_count;
  reg pq_prev_bit;
  reg pq_have_prev;
  reg [7:0] next_pq_count;
  wire [7:0] pq_thr;

  assign pq_thr = {3'b000, i_preamble_quality_threshold, 2'b00};

  // Counter saturates at both ends so noise cannot wrap it into a pass
  // The first bit after a restart only primes the previous-bit store
  always @* begin
    next_pq_count = pq_count;
    if (i_rx_bit_valid && pq_have_prev) begin
      if (i_rx_bit != pq_prev_bit) begin
        if (pq_count != `FSPC_PQ_MAX) begin
          next_pq_count = pq_count + 8'h01;
        end
      end else if (pq_count >= `FSPC_PQ_DEC) begin
        next_pq_count = pq_count - `FSPC_PQ_DEC;
      end else begin
        next_pq_count = 8'h00;
      end
    end
  end

  always @(posedge i_clk_sys) begin
    if (i_sys_rst || i_pq_restart) begin
      pq_count <= 8'h00;
      pq_prev_bit <= 1'b0;
      pq_have_prev <= 1'b0;
      o_sync_gate <= 1'b0;
    end else begin
      pq_count <= next_pq_count;
      if (i_rx_bit_valid) begin
        pq_prev_bit <= i_rx_bit;
        pq_have_prev <= 1'b1;
      end
      o_sync_gate <= (i_preamble_quality_threshold == 3'b000) ||
        (next_pq_count >= pq_thr);
    end
  end

endmodule // fspc_fifo_sync_packet_config
`default_nettype wire

//--- tb/fspc_chk.sv
// Port checker for the packet config bank
`timescale 1ns/1ps
`default_nettype none
module fspc_chk (
  // Clock, reset, writes
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic [5:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  // Wake
  input wire logic i_wake,
  input wire logic [7:0] o_analog_trim_one,
  input wire logic [7:0] o_analog_trim_two,
  // Fill levels
  input wire logic [6:0] i_tx_fifo_bytes,
  input wire logic [6:0] i_rx_fifo_bytes,
  input wire logic o_tx_thr_reached,
  input wire logic o_rx_thr_reached,
  // Sync and length
  input wire logic [15:0] o_sync_word,
  input wire logic i_len_fixed_mode,
  input wire logic [7:0] i_len_field,
  input wire logic i_len_field_valid,
  input wire logic [7:0] o_pkt_length,
  input wire logic o_pkt_len_reject
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  logic [3:0] n;
  logic [7:0] lim;
  logic ret;
  ////////////////////////////////////////
  // Shadows follow the host writes so the checks need no register peek
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      {ret, n, lim} <= 13'h07ff;
    end else if (i_reg_wr && i_reg_addr == 6'h03) begin
      {ret, n} <= {i_reg_wdata[6], i_reg_wdata[3:0]};
    end else if (i_reg_wr && i_reg_addr == 6'h06) begin
      lim <= i_reg_wdata;
    end
  end
  sequence s_wr(a);
    i_reg_wr && i_reg_addr == a;
  endsequence
  sequence s_len;
    i_len_field_valid && !i_len_fixed_mode;
  endsequence
  ////////////////////////////////////////
  trim_wake_a: assert property (
    i_wake |=> {o_analog_trim_one, o_analog_trim_two} ==
    ($past(ret) ? 16'h3581 : 16'h3188)) else $error("bad wake trims");
  trim_hold_a: assert property (
    !i_wake |=> $stable({o_analog_trim_one, o_analog_trim_two}))
    else $error("trim moved");
  rx_thr_a: assert property (
    !$past(i_sys_rst) |-> o_rx_thr_reached == ($past(i_rx_fifo_bytes) >=
    {$past(n) + 5'h01, 2'b00})) else $error("rx flag wrong");
  tx_thr_a: assert property (
    !$past(i_sys_rst) |-> o_tx_thr_reached == ($past(i_tx_fifo_bytes) >=
    7'h3d - {1'b0, $past(n), 2'b00})) else $error("tx flag wrong");
  sync_high_a: assert property (
    s_wr(6'h04) |-> ##2 o_sync_word[15:8] == $past(i_reg_wdata, 2))
    else $error("sync high stale");
  sync_low_a: assert property (
    s_wr(6'h05) |-> ##2 o_sync_word[7:0] == $past(i_reg_wdata, 2))
    else $error("sync low stale");
  len_fixed_a: assert property (
    i_len_fixed_mode |=> o_pkt_length == $past(lim) && !o_pkt_len_reject)
    else $error("fixed length wrong");
  len_var_a: assert property (
    i_len_field_valid && !i_len_fixed_mode |=> o_pkt_len_reject ==
    ($past(i_len_field) > $past(lim))) else $error("limit check wrong");
  len_accept_a: assert property (
    s_len |=> o_pkt_length == ($past(i_len_field) > $past(lim) ?
    $past(lim) : $past(i_len_field))) else $error("length pass wrong");
endmodule // fspc_chk
bind fspc_fifo_sync_packet_config fspc_chk u_fspc_chk (
  .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
  .i_wake(i_wake), .o_analog_trim_one(o_analog_trim_one),
  .o_analog_trim_two(o_analog_trim_two),
  .i_tx_fifo_bytes(i_tx_fifo_bytes), .i_rx_fifo_bytes(i_rx_fifo_bytes),
  .o_tx_thr_reached(o_tx_thr_reached), .o_rx_thr_reached(o_rx_thr_reached),
  .o_sync_word(o_sync_word), .i_len_fixed_mode(i_len_fixed_mode),
  .i_len_field(i_len_field), .i_len_field_valid(i_len_field_valid),
  .o_pkt_length(o_pkt_length), .o_pkt_len_reject(o_pkt_len_reject));
`default_nettype wire

//--- tb/fspc_host.sv
// Host model driving the register port
`timescale 1ns/1ps
`default_nettype none
module fspc_host (
  // Clock
  input wire logic i_clk_sys,
  // Register port
  output logic [5:0] o_reg_addr,
  output logic [7:0] o_reg_wdata,
  output logic o_reg_wr,
  output logic o_reg_rd
);
  initial {o_reg_addr, o_reg_wdata, o_reg_wr, o_reg_rd} = '0;
  ////////////////////////////////////////
  task automatic acc(input logic w, input logic [5:0] a,
      input logic [7:0] d);
    @(negedge i_clk_sys);
    o_reg_addr = a;
    o_reg_wdata = a == 6'h03 ? d & 8'h7f : a == 6'h06 && d == 8'h00 ? 8'h01 : d;
    {o_reg_wr, o_reg_rd} = {w, !w};
    @(negedge i_clk_sys);
    {o_reg_wr, o_reg_rd} = 2'b00;
    // Released data never keeps its last value
    o_reg_wdata = ~o_reg_wdata;
  endtask
endmodule // fspc_host
`default_nettype wire

//--- tb/test_fspc_fifo_sync_packet_config.sv
// Self-checking bench for the packet config bank
`timescale 1ns/1ps
`default_nettype none
`include "fspc_defines.vh"
module test_fspc_fifo_sync_packet_config;
  logic i_clk_sys = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [5:0] i_reg_addr;
  logic [7:0] i_reg_wdata, o_reg_rdata, o_analog_trim_one, o_analog_trim_two;
  logic i_reg_wr, i_reg_rd, o_reg_rvalid, i_wake, o_tx_thr_reached;
  logic o_rx_thr_reached, i_len_fixed_mode, i_len_field_valid, i_rx_bit;
  logic o_pkt_len_reject, i_rx_bit_valid, i_pq_restart, o_sync_gate;
  logic [6:0] i_tx_fifo_bytes, i_rx_fifo_bytes;
  logic [15:0] o_sync_word;
  logic [1:0] o_close_in_rx;
  logic [7:0] i_len_field, o_pkt_length, v;
  logic [2:0] i_preamble_quality_threshold;
  logic [7:0] exp_q[$];
  int miscompares, checked;
  always #20 i_clk_sys = ~i_clk_sys;
  fspc_fifo_sync_packet_config u_fspc_fifo_sync_packet_config (.*);
  fspc_host u_fspc_host (.i_clk_sys(i_clk_sys), .o_reg_addr(i_reg_addr),
    .o_reg_wdata(i_reg_wdata), .o_reg_wr(i_reg_wr), .o_reg_rd(i_reg_rd));
  ////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    checked++;
    if (got !== want) begin
      miscompares++;
      $display("wrong value at %0t: %h expected %h", $time, got, want);
    end
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_fspc_host.acc(1'b0, a, 8'h00);
  endtask
  task automatic step;
    @(negedge i_clk_sys);
  endtask
  task automatic test_done;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Read valid lasts one cycle; its data is matched to the oldest note
  always @(negedge i_clk_sys) if (o_reg_rvalid === 1'b1) begin
    if (exp_q.size() == 0) miscompares++;
    else chk(o_reg_rdata, exp_q.pop_front());
  end
  ////////////////////////////////////////
  initial begin
    {i_wake, i_tx_fifo_bytes, i_rx_fifo_bytes, i_len_fixed_mode, i_rx_bit,
      i_len_field, i_len_field_valid, i_preamble_quality_threshold} = '0;
    {i_rx_bit_valid, i_pq_restart} = 2'b00;
    v = 8'($urandom(32'h7c8e_53b4));
    repeat (4) step;
    i_sys_rst = 1'b0;
    rd(6'h03, `FSPC_RST_FILL_LEVEL_THRESHOLD);
    rd(6'h04, `FSPC_RST_SYNC_HIGH);
    rd(6'h05, `FSPC_RST_SYNC_LOW);
    rd(6'h06, `FSPC_RST_PKT_LEN);
    rd(6'h10, 8'h00);
    $display("reset test done");
    v = 8'($urandom);
    u_fspc_host.acc(1'b1, 6'h04, v);
    u_fspc_host.acc(1'b1, 6'h05, ~v);
    step;
    chk(o_sync_word, {v, ~v});
    rd(6'h04, v);
    $display("sync test done");
    for (int n = 0; n < 16; n++) begin
      v = {4'($urandom), n[3:0]};
      u_fspc_host.acc(1'b1, 6'h03, v);
      i_rx_fifo_bytes = 7'(4 * n + 3);
      i_tx_fifo_bytes = 7'(60 - 4 * n);
      step;
      chk({o_rx_thr_reached, o_tx_thr_reached}, 2'b00);
      chk(o_close_in_rx, v[5:4]);
      i_rx_fifo_bytes++;
      i_tx_fifo_bytes++;
      step;
      chk({o_rx_thr_reached, o_tx_thr_reached}, 2'b11);
    end
    $display("threshold test done");
    for (int r = 0; r < 2; r++) begin
      u_fspc_host.acc(1'b1, 6'h03, {1'b0, r[0], 6'h07});
      i_wake = 1'b1;
      step;
      i_wake = 1'b0;
      chk({o_analog_trim_one, o_analog_trim_two}, r ? 16'h3581 : 16'h3188);
      rd(6'h2D, `FSPC_RST_TRIM_ONE);
      rd(6'h2C, `FSPC_RST_TRIM_TWO);
    end
    $display("wake test done");
    u_fspc_host.acc(1'b1, 6'h06, 8'h00);
    rd(6'h06, 8'h01);
    v = 8'($urandom_range(254, 1));
    u_fspc_host.acc(1'b1, 6'h06, v);
    i_len_fixed_mode = 1'b1;
    step;
    chk({o_pkt_len_reject, o_pkt_length}, {1'b0, v});
    i_len_fixed_mode = 1'b0;
    for (int k = 0; k < 3; k++) begin
      {i_len_field, i_len_field_valid} = {v + 8'h01 - k[7:0], 1'b1};
      step;
      i_len_field_valid = 1'b0;
      chk({o_pkt_len_reject, o_pkt_length}, {k == 0, v - 8'(k / 2)});
    end
    $display("length test done");
    {i_preamble_quality_threshold, i_pq_restart} = 4'h3;
    step;
    i_pq_restart = 1'b0;
    for (int b = 0; b < 6; b++) begin
      {i_rx_bit, i_rx_bit_valid} = {b[0] ^ (b == 5), 1'b1};
      step;
      if (b > 3) chk(o_sync_gate, b == 4);
    end
    i_rx_bit_valid = 1'b0;
    i_preamble_quality_threshold = 3'h0;
    step;
    chk(o_sync_gate, 1'b1);
    $display("preamble test done");
    // Second reset after the registers have been rewritten
    i_sys_rst = 1'b1;
    step;
    i_sys_rst = 1'b0;
    chk({o_pkt_len_reject, o_pkt_length}, {1'b0, `FSPC_RST_PKT_LEN});
    chk(o_sync_word, {`FSPC_RST_SYNC_HIGH, `FSPC_RST_SYNC_LOW});
    chk({o_analog_trim_one, o_analog_trim_two}, 16'h3188);
    rd(6'h06, `FSPC_RST_PKT_LEN);
    rd(6'h03, `FSPC_RST_FILL_LEVEL_THRESHOLD);
    $display("second reset test done");
    repeat (4) step;
    if (exp_q.size() != 0) miscompares++;
    test_done;
  end
endmodule // test_fspc_fifo_sync_packet_config
`default_nettype wire
